// File: rtl/vtf_params.svh
// Register offsets, field positions, reset values and constants
`ifndef VTF_PARAMS_SVH
`define VTF_PARAMS_SVH
// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define VTF_A_VID 8'h00
`define VTF_A_MEMB 8'h04
`define VTF_A_FORB 8'h08
`define VTF_A_TAG 8'h0c
`define VTF_A_ACT 8'h10
`define VTF_A_GO 8'h14
`define VTF_A_FWD 8'h18
`define VTF_A_DROP 8'h1c
`define VTF_A_PVID0 8'h40
// ----------------------------------------------------------------
// Fields
// ----------------------------------------------------------------
`define VTF_GO_WR 0
`define VTF_GO_RD 1
`define VTF_TCI_CFI 12
`define VTF_TCI_PCP_LSB 13
// ----------------------------------------------------------------
// Values
// ----------------------------------------------------------------
`define VTF_PVID_RST 12'h001
`define VTF_VID_NULL 12'h000
`define VTF_VID_RSVD 12'hfff
`define VTF_TPID 16'h8100
`define VTF_INIT_LAST 12'hfff
`endif

// File: rtl/vtf_pkg.sv
// Types shared by the VLAN forwarding engine
package vtf_pkg;
   localparam int VTF_MAXP = 16;
   typedef logic [11:0] vtf_vid_t;
   typedef logic [3:0] vtf_port_t;
   typedef logic [VTF_MAXP-1:0] vtf_pmask_t;
   // Ingress frame header descriptor
   typedef struct packed {
      vtf_port_t port;
      logic [15:0] etype;
      logic [15:0] tci;
      logic bcast;
      logic da_known;
      vtf_port_t da_port;
   } vtf_rx_s;
   // Egress forwarding decision
   typedef struct packed {
      logic drop;
      logic rx_tagged;
      vtf_pmask_t port_mask;
      vtf_pmask_t tag_mask;
      vtf_pmask_t fcs_mask;
      logic [15:0] tci;
   } vtf_tx_s;
   // One VLAN table entry
   typedef struct packed {
      logic active;
      vtf_pmask_t memb;
      vtf_pmask_t forb;
      vtf_pmask_t tag;
   } vtf_ent_s;
endpackage : vtf_pkg

// File: rtl/vtf_vlan_ram.sv
// VLAN table memory, one write port and two registered read ports
module vtf_vlan_ram #(
   parameter int DW = 49,
   parameter int AW = 12
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // Read port A
   input wire logic a_en,
   input wire logic [AW-1:0] a_addr,
   output logic [DW-1:0] a_q,
   // Read port B
   input wire logic b_en,
   input wire logic [AW-1:0] b_addr,
   output logic [DW-1:0] b_q
);
   logic [DW-1:0] mem [2**AW];

   always_ff @(posedge clk) begin
      if (we) begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         a_q <= '0;
         b_q <= '0;
      end else begin
         if (a_en) a_q <= mem[a_addr];
         if (b_en) b_q <= mem[b_addr];
      end
   end
endmodule : vtf_vlan_ram

// File: rtl/vtf_engine.sv
// VLAN classification, egress filtering and tag decision engine
//
// Summary of operation
// (RQ1) Tagged frame is four bytes longer
// (RQ2) Tag control: priority, CFI, 12-bit VID
// (RQ3) Generated tags carry CFI zero
// (RQ4) CFI-set frames never leave untagged ports
// (RQ5) VID zero takes ingress default VID
// (RQ6) VIDs 1-4094 valid, 4095 reserved
// (RQ7) Every port sends, receives tagged and untagged
// (RQ8) Decide ports first, then strip tag
// (RQ9) Decide ports first, then insert default tag
// (RQ10) Port default VID resets to 1
// (RQ11) Egress from destination and VID together
// (RQ12) Unicast to non-member port is dropped
// (RQ13) Broadcast to members except ingress port
// (RQ14) Per-port per-VLAN tagging enable picks format
// (RQ15) Forbidden ports never become members
// (RQ16) Tag type 0x8100, redo FCS on change
// (RQ17) Reserved or unknown VID is discarded
`include "vtf_params.svh"

module vtf_engine
   import vtf_pkg::*;
#(
   parameter int NPORTS = 14
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Ingress descriptors
   input wire logic rx_valid,
   output logic rx_ready,
   input wire vtf_rx_s rx,
   // Egress decisions
   output logic tx_valid,
   input wire logic tx_ready,
   output vtf_tx_s tx
);
   localparam vtf_pmask_t PORTS_M =
      VTF_MAXP'((33'h1 << NPORTS) - 33'h1);

   // -------------------------------------------------------------
   // Configuration state
   // -------------------------------------------------------------
   vtf_vid_t pvid [VTF_MAXP];
   vtf_vid_t vt_vid;
   vtf_pmask_t vt_memb;
   vtf_pmask_t vt_forb;
   vtf_pmask_t vt_tag;
   logic vt_act;
   logic fetch_pend;
   logic init_busy;
   vtf_vid_t init_vid;
   logic [31:0] fwd_cnt;
   logic [31:0] drop_cnt;

   // -------------------------------------------------------------
   // APB decode
   // -------------------------------------------------------------
   wire acc = psel & penable;
   wire wr = acc & pwrite;
   wire setup_rd = psel & ~penable & ~pwrite;
   wire [7:0] poff = paddr - `VTF_A_PVID0;
   wire [3:0] pidx = poff[5:2];
   wire hit_pvid = poff[7:6] == 2'b00 && poff[1:0] == 2'b00
      && 32'(pidx) < NPORTS;
   wire hit_vid = paddr == `VTF_A_VID;
   wire hit_memb = paddr == `VTF_A_MEMB;
   wire hit_forb = paddr == `VTF_A_FORB;
   wire hit_tag = paddr == `VTF_A_TAG;
   wire hit_act = paddr == `VTF_A_ACT;
   wire hit_go = paddr == `VTF_A_GO;
   wire hit_fwd = paddr == `VTF_A_FWD;
   wire hit_drop = paddr == `VTF_A_DROP;
   wire mapped = hit_pvid | hit_vid | hit_memb | hit_forb | hit_tag
      | hit_act | hit_go | hit_fwd | hit_drop;
   // Software table writes only for real VLANs; 0 and 4095 only get the init sweep's cleared entries
   wire vid_ok = vt_vid != `VTF_VID_NULL
      && vt_vid != `VTF_VID_RSVD; // [RQ6]
   wire go_wr = wr & hit_go & pwdata[`VTF_GO_WR] & ~init_busy;
   wire go_rd = wr & hit_go & pwdata[`VTF_GO_RD];
   wire [31:0] rd_mux =
      hit_pvid ? {20'h0, pvid[pidx]} :
      hit_vid ? {20'h0, vt_vid} :
      hit_memb ? {16'h0, vt_memb} :
      hit_forb ? {16'h0, vt_forb} :
      hit_tag ? {16'h0, vt_tag} :
      hit_act ? {31'h0, vt_act} :
      hit_go ? {31'h0, init_busy} :
      hit_fwd ? fwd_cnt :
      hit_drop ? drop_cnt : 32'h0;

   assign pready = 1'b1;
   assign pslverr = acc & ~mapped;

   // Read data captured in setup so it is a flop in the access phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h0;
      else if (setup_rd) prdata <= rd_mux;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < VTF_MAXP; i++) begin
            pvid[i] <= `VTF_PVID_RST; // [RQ10]
         end
      end else if (wr && hit_pvid) begin
         pvid[pidx] <= pwdata[11:0]; // [RQ10]
      end
   end

   // -------------------------------------------------------------
   // VLAN table staging registers
   // -------------------------------------------------------------
   vtf_ent_s fetch_q;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vt_vid <= `VTF_VID_NULL;
         vt_memb <= '0;
         vt_forb <= '0;
         vt_tag <= '0;
         vt_act <= 1'b0;
         fetch_pend <= 1'b0;
      end else begin
         fetch_pend <= go_rd;
         if (fetch_pend) begin
            vt_memb <= fetch_q.memb;
            vt_forb <= fetch_q.forb;
            vt_tag <= fetch_q.tag;
            vt_act <= fetch_q.active;
         end
         // A software write in the same cycle overrides the fetch
         if (wr && hit_vid) vt_vid <= pwdata[11:0];
         if (wr && hit_memb) vt_memb <= pwdata[15:0] & PORTS_M;
         if (wr && hit_forb) vt_forb <= pwdata[15:0] & PORTS_M;
         if (wr && hit_tag) vt_tag <= pwdata[15:0] & PORTS_M;
         if (wr && hit_act) vt_act <= pwdata[0];
      end
   end

   // -------------------------------------------------------------
   // Table initialisation sweep
   // -------------------------------------------------------------
   // The table has no reset; every VID is cleared after reset and
   // the default VLAN gets all ports as untagged members.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_busy <= 1'b1;
         init_vid <= `VTF_VID_NULL;
      end else if (init_busy) begin
         init_vid <= init_vid + 12'h1;
         if (init_vid == `VTF_INIT_LAST) init_busy <= 1'b0;
      end
   end

   vtf_ent_s sw_ent;
   vtf_ent_s init_ent;
   vtf_ent_s wr_ent;
   assign sw_ent.active = vt_act;
   assign sw_ent.memb = vt_memb & ~vt_forb; // [RQ15]
   assign sw_ent.forb = vt_forb;
   assign sw_ent.tag = vt_tag & ~vt_forb;
   wire init_dflt = init_vid == `VTF_PVID_RST;
   assign init_ent.active = init_dflt;
   assign init_ent.memb = init_dflt ? PORTS_M : '0;
   assign init_ent.forb = '0;
   assign init_ent.tag = '0;
   assign wr_ent = init_busy ? init_ent : sw_ent;
   wire tbl_we = init_busy | (go_wr & vid_ok); // [RQ6]
   wire [11:0] tbl_wa = init_busy ? init_vid : vt_vid;

   // -------------------------------------------------------------
   // Ingress classification
   // -------------------------------------------------------------
   vtf_rx_s s1;
   logic s1_valid;
   logic s1_tag;
   logic s1_prio;
   vtf_vid_t s1_vid;
   logic v0;
   logic v1;

   wire adv = ~s1_valid | ~v1;
   wire take = rx_valid & rx_ready;
   assign rx_ready = adv & ~init_busy;
   wire in_tag = rx.etype == `VTF_TPID; // [RQ16]
   wire [11:0] in_vid = rx.tci[11:0]; // [RQ2]
   wire in_vid0 = in_vid == `VTF_VID_NULL;
   wire [11:0] in_pvid = pvid[rx.port];
   // Untagged and priority frames take the port default VID
   wire [11:0] res_vid =
      (~in_tag | in_vid0) ? in_pvid : in_vid; // [RQ5] [RQ9]

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_valid <= 1'b0;
         s1 <= '0;
         s1_tag <= 1'b0;
         s1_prio <= 1'b0;
         s1_vid <= `VTF_VID_NULL;
      end else if (adv) begin
         s1_valid <= take;
         s1 <= rx;
         s1_tag <= in_tag;
         s1_prio <= in_tag & in_vid0;
         s1_vid <= res_vid;
      end
   end

   vtf_ent_s ent;
   vtf_vlan_ram #(
      .DW($bits(vtf_ent_s)),
      .AW(12)
   ) u_ram (
      .clk(pclk),
      .rst_n(presetn),
      .we(tbl_we),
      .waddr(tbl_wa),
      .wdata(wr_ent),
      .a_en(go_rd),
      .a_addr(vt_vid),
      .a_q(fetch_q),
      .b_en(adv),
      .b_addr(res_vid),
      .b_q(ent)
   );

   // -------------------------------------------------------------
   // Egress filtering and tag decision
   // -------------------------------------------------------------
   wire bad_port = 32'(s1.port) >= NPORTS;
   wire vid_bad = s1_vid == `VTF_VID_NULL
      || s1_vid == `VTF_VID_RSVD || ~ent.active; // [RQ6] [RQ17]
   wire [15:0] memb = ent.memb & ~ent.forb & PORTS_M; // [RQ15]
   wire [15:0] in_oh = 16'h1 << s1.port;
   wire [15:0] da_oh = 16'h1 << s1.da_port;
   wire flood = s1.bcast | ~s1.da_known;
   // Unknown unicast floods like broadcast inside the VLAN
   wire [15:0] cand = (flood ? memb : (da_oh & memb))
      & ~in_oh; // [RQ11] [RQ12] [RQ13]
   wire [15:0] tag_c = ent.tag & cand; // [RQ14] [RQ7]
   wire rx_cfi = s1_tag & s1.tci[`VTF_TCI_CFI];
   wire [15:0] pm = (vid_bad | bad_port) ? 16'h0
      : cand & ~(rx_cfi ? ~tag_c : 16'h0); // [RQ4]
   wire [15:0] tm = tag_c & pm;
   // A tag is generated for untagged or priority frames
   wire regen = ~s1_tag | s1_prio;
   wire [2:0] pcp = s1_tag ? s1.tci[15:`VTF_TCI_PCP_LSB] : 3'h0;
   // Length changes by a tag on insert or strip, so FCS is redone
   wire [15:0] fcs = pm & ((tm & {16{regen}})
      | (~tm & {16{s1_tag}})); // [RQ1] [RQ8] [RQ9] [RQ16]

   vtf_tx_s nx;
   assign nx.drop = pm == 16'h0;
   assign nx.rx_tagged = s1_tag;
   assign nx.port_mask = pm;
   assign nx.tag_mask = tm;
   assign nx.fcs_mask = fcs;
   assign nx.tci = {pcp, ~regen & rx_cfi, s1_vid}; // [RQ3] [RQ5]

   // -------------------------------------------------------------
   // Two-entry egress buffer
   // -------------------------------------------------------------
   // Head sits in a flop so decision data never passes logic
   vtf_tx_s q1;
   wire push = s1_valid & ~v1;
   wire pop = v0 & tx_ready;
   assign tx_valid = v0;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         v0 <= 1'b0;
         v1 <= 1'b0;
         tx <= '0;
         q1 <= '0;
      end else if (pop) begin
         if (v1) tx <= q1;
         else if (push) tx <= nx;
         v0 <= v1 | push;
         v1 <= 1'b0;
      end else if (push) begin
         if (v0) q1 <= nx;
         else tx <= nx;
         v0 <= 1'b1;
         v1 <= v0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fwd_cnt <= 32'h0;
         drop_cnt <= 32'h0;
      end else if (push) begin
         if (nx.drop) drop_cnt <= drop_cnt + 32'h1;
         else fwd_cnt <= fwd_cnt + 32'h1;
      end
   end

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   property p_cfi_gen; // [RQ3]
      push && regen |-> nx.tci[`VTF_TCI_CFI] == 1'b0;
   endproperty
   a_cfi_gen: assert property (p_cfi_gen) // [RQ3]
      else $error("generated tag has CFI set");

   property p_cfi_untag; // [RQ4]
      tx_valid && tx.tci[`VTF_TCI_CFI]
         |-> (tx.port_mask & ~tx.tag_mask) == 16'h0;
   endproperty
   a_cfi_untag: assert property (p_cfi_untag) // [RQ4]
      else $error("CFI frame sent to untagged port");

   property p_prio; // [RQ5]
      take && in_tag && in_vid0 |=> s1_vid == $past(in_pvid);
   endproperty
   a_prio: assert property (p_prio) // [RQ5]
      else $error("priority frame not given port VID");

   property p_rsvd; // [RQ6]
      push && (s1_vid == `VTF_VID_RSVD || ~ent.active)
         |-> nx.drop;
   endproperty
   a_rsvd: assert property (p_rsvd) // [RQ6]
      else $error("reserved or unknown VID forwarded");

   property p_pvid_wr; // [RQ10]
      wr && hit_pvid && pidx == 4'h0
         |=> pvid[0] == $past(pwdata[11:0]);
   endproperty
   a_pvid_wr: assert property (p_pvid_wr) // [RQ10]
      else $error("port VID write not applied");

   property p_ucast; // [RQ12]
      push && ~flood |-> (nx.port_mask & ~(da_oh & memb)) == 16'h0;
   endproperty
   a_ucast: assert property (p_ucast) // [RQ12]
      else $error("unicast sent to non-member port");

   property p_bcast; // [RQ13]
      push && s1.bcast |-> (nx.port_mask & in_oh) == 16'h0;
   endproperty
   a_bcast: assert property (p_bcast) // [RQ13]
      else $error("broadcast sent back to ingress port");

   property p_forb; // [RQ15]
      push |-> (nx.port_mask & ent.forb) == 16'h0;
   endproperty
   a_forb: assert property (p_forb) // [RQ15]
      else $error("frame sent to forbidden port");

   property p_latency; // [RQ8]
      take && ~v1 |=> s1_valid ##1 tx_valid;
   endproperty
   a_latency: assert property (p_latency) // [RQ8]
      else $error("decision not presented in two cycles");

   property p_hold;
      tx_valid && !tx_ready |=> tx_valid && $stable(tx);
   endproperty
   a_hold: assert property (p_hold)
      else $error("egress decision changed while stalled");
endmodule : vtf_engine

// File: dv/vtf_sink.sv
// Egress sink model that paces the forwarding decision stream
module vtf_sink
   import vtf_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Pacing from the bench
   input wire logic stall,
   input wire logic slow,
   // Decision handshake
   output logic tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   // Slow mode refuses every other cycle to skew buffer timing
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_ready <= 1'b0;
      end else begin
         tx_ready <= !stall && (!slow || !tx_ready);
      end
   end
endmodule : vtf_sink

// File: dv/testbench.sv
// Self-checking bench for the VLAN forwarding engine
`include "vtf_params.svh"
module testbench
   import vtf_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   logic pclk, presetn, psel, penable, pwrite, rx_valid, stall, slow;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, q;
   logic pready, pslverr, rx_ready, tx_valid, tx_ready, e;
   vtf_rx_s rx;
   vtf_tx_s tx;
   vtf_tx_s exp_q[$];
   vtf_tx_s care_q[$];
   int error_cnt = 0;
   int cmp_count = 0;
   // Fields compared; a rewritten priority tag leaves fcs unchecked
   localparam vtf_tx_s C_ALL = '{1'b1, 1'b1, 16'hffff, 16'hffff, 16'hffff,
                                 16'hffff};
   localparam vtf_tx_s C_PRI = '{1'b1, 1'b1, 16'hffff, 16'hffff, 16'h0,
                                 16'hffff};
   localparam vtf_tx_s C_PM = '{1'b0, 1'b0, 16'hffff, 16'h0, 16'h0, 16'h0};
   localparam vtf_tx_s C_DRP = '{1'b1, 1'b0, 16'hffff, 16'h0, 16'h0,
                                 16'h0};

   vtf_engine DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx(rx),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx(tx));
   vtf_sink sink (.pclk(pclk), .presetn(presetn), .stall(stall),
      .slow(slow), .tx_ready(tx_ready));

   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic cmp(input logic [65:0] got, input logic [65:0] exp);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got,
                  exp);
      end
   endtask : cmp

   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      cmp(q, x);
   endtask : rd

   function automatic vtf_rx_s mk(input vtf_port_t p, input logic tg,
      input logic [15:0] t, input logic bc, input logic kn,
      input vtf_port_t dp);
      mk = '{port:p, etype:(tg ? `VTF_TPID : 16'h0800), tci:t, bcast:bc,
             da_known:kn, da_port:dp};
   endfunction : mk

   function automatic vtf_tx_s ex(input logic dr, input logic rt,
      input vtf_pmask_t pm, input vtf_pmask_t tm, input logic [15:0] t);
      // FCS redone where a tag is inserted or stripped
      ex = '{drop:dr, rx_tagged:rt, port_mask:pm, tag_mask:tm,
             fcs_mask:pm & (rt ? ~tm : tm), tci:t};
   endfunction : ex

   task automatic send(input vtf_rx_s d, input vtf_tx_s x,
                       input vtf_tx_s c);
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx <= d;
      exp_q.push_back(vtf_tx_s'(x & c));
      care_q.push_back(c);
      do @(posedge pclk); while (rx_ready !== 1'b1);
      rx_valid <= 1'b0;
   endtask : send

   task automatic drain(input string n);
      for (int i = 0; i < 300 && exp_q.size() != 0; i++) @(posedge pclk);
      cmp(exp_q.size(), 0);
      $display("test %0s finished", n);
   endtask : drain

   task automatic print_verdict();
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : print_verdict

   // Decisions must come out in the order the descriptors went in
   always @(posedge pclk) begin
      if (presetn && tx_valid === 1'b1 && tx_ready === 1'b1) begin
         if (exp_q.size() == 0) begin
            cmp(tx, 66'h0);
         end else begin
            cmp(tx & care_q[0], exp_q[0]);
            void'(exp_q.pop_front());
            void'(care_q.pop_front());
         end
      end
   end

   initial begin
      repeat (40000) @(posedge pclk);
      error_cnt++;
      $display("watchdog expired");
      print_verdict();
   end
   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      presetn = 1'b0;
      {psel, penable, pwrite, rx_valid, stall, slow} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      rx = '0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(`VTF_A_PVID0, 32'h1);
      rd(8'h74, 32'h1);
      cmp(rx_ready, 1'b0);
      rd(8'h20, 32'h0);
      cmp(e, 1'b1);
      $display("test reset finished");
      // Table is unusable until the init sweep is over
      for (int i = 0; i < 2000; i++) begin
         apb(1'b0, `VTF_A_GO, 32'h0);
         if (q[0] === 1'b0) break;
      end
      cmp(q[0], 1'b0);
      apb(1'b1, `VTF_A_VID, 32'h5);
      apb(1'b1, `VTF_A_MEMB, 32'hf);
      apb(1'b1, `VTF_A_FORB, 32'h8);
      apb(1'b1, `VTF_A_TAG, 32'ha);
      apb(1'b1, `VTF_A_ACT, 32'h1);
      apb(1'b1, `VTF_A_GO, 32'h1);
      apb(1'b1, `VTF_A_PVID0, 32'h5);
      apb(1'b1, `VTF_A_GO, 32'h2);
      repeat (2) @(posedge pclk);
      rd(`VTF_A_MEMB, 32'h7);
      rd(`VTF_A_TAG, 32'h2);
      $display("test config finished");
      send(mk(0, 0, 0, 1, 0, 0),
         ex(0, 0, 6, 2, 16'h5), C_ALL);
      send(mk(2, 1, 16'h6005, 0, 1, 1),
         ex(0, 1, 2, 2, 16'h6005), C_ALL);
      send(mk(1, 1, 16'h6005, 0, 1, 2),
         ex(0, 1, 4, 0, 16'h6005), C_ALL);
      send(mk(0, 1, 16'h1005, 1, 0, 0), ex(0, 0, 2, 0, 0), C_PM);
      send(mk(0, 1, 16'ha000, 0, 1, 1),
         ex(0, 1, 2, 2, 16'ha005), C_PRI);
      send(mk(2, 1, 16'h0005, 0, 1, 4), ex(1, 0, 0, 0, 0), C_DRP);
      send(mk(0, 1, 16'h0fff, 1, 0, 0), ex(1, 0, 0, 0, 0), C_DRP);
      send(mk(0, 1, 16'h0007, 1, 0, 0), ex(1, 0, 0, 0, 0), C_DRP);
      send(mk(1, 0, 0, 0, 0, 3),
         ex(0, 0, 16'h3ffd, 0, 16'h1), C_ALL);
      drain("forwarding");
      rd(`VTF_A_FWD, 32'h6);
      rd(`VTF_A_DROP, 32'h3);
      // Receiver stalls long enough to fill the buffer
      stall <= 1'b1;
      fork
         repeat (6) send(mk(0, 0, 0, 1, 0, 0),
            ex(0, 0, 6, 2, 16'h5), C_ALL);
         begin
            repeat (40) @(posedge pclk);
            cmp(rx_ready, 1'b0);
            stall <= 1'b0;
            slow <= 1'b1;
         end
      join
      drain("stall");
      print_verdict();
   end
endmodule : testbench
